/* File: rtl/sap_pkg.sv */
package sap_pkg;

	localparam int unsigned SAP_CHANNELS = 2;
	localparam int unsigned SAP_DATA_W = 32;
	localparam int unsigned SAP_FIFO_DEPTH = 16;
	localparam int unsigned SAP_PTR_W = 4;
	localparam int unsigned SAP_LVL_W = 5;
	localparam int unsigned SAP_ST_PER_CH = 4;

	// register byte addresses
	localparam logic [7:0] SAP_OFF_CONTROL = 8'h00;
	localparam logic [7:0] SAP_OFF_MCLK = 8'h04;
	localparam logic [7:0] SAP_OFF_STATUS = 8'h08;
	localparam logic [7:0] SAP_OFF_MASK = 8'h0C;
	localparam logic [7:0] SAP_CH_BASE = 8'h20;
	localparam logic [7:0] SAP_CH_STRIDE = 8'h20;
	localparam logic [7:0] SAP_CH_MASK = 8'hE0;
	localparam logic [7:0] SAP_CH_CONFIG = 8'h00;
	localparam logic [7:0] SAP_CH_THRESH = 8'h04;
	localparam logic [7:0] SAP_CH_TXDATA = 8'h08;
	localparam logic [7:0] SAP_CH_RXDATA = 8'h0C;
	localparam logic [7:0] SAP_CH_LEVEL = 8'h10;

	// field positions
	localparam int unsigned SAP_CFG_DIR_LSB = 0;
	localparam int unsigned SAP_CFG_FMT_LSB = 2;
	localparam int unsigned SAP_CFG_SLAVE_BIT = 4;
	localparam int unsigned SAP_CFG_SWAP_BIT = 5;
	localparam int unsigned SAP_CFG_WIDTH_LSB = 8;
	localparam int unsigned SAP_CFG_RATIO_LSB = 16;
	localparam int unsigned SAP_THR_RX_LSB = 0;
	localparam int unsigned SAP_THR_TX_LSB = 8;
	localparam int unsigned SAP_LVL_TX_LSB = 0;
	localparam int unsigned SAP_LVL_RX_LSB = 8;
	localparam int unsigned SAP_LVL_TXE_BIT = 16;
	localparam int unsigned SAP_LVL_RXF_BIT = 17;
	localparam int unsigned SAP_ST_TXE = 0;
	localparam int unsigned SAP_ST_RXF = 1;
	localparam int unsigned SAP_ST_UNDER = 2;
	localparam int unsigned SAP_ST_OVER = 3;

	// values after reset, and write limits
	localparam logic SAP_RST_ENHANCED = 1'b1;
	localparam logic [13:0] SAP_RST_MCLK = 14'h0100;
	localparam logic [13:0] SAP_MCLK_MIN = 14'h0010;
	localparam logic [13:0] SAP_MCLK_MAX = 14'h2000;
	localparam logic [1:0] SAP_RST_DIR_CH0 = 2'h2;
	localparam logic [1:0] SAP_RST_DIR_CH1 = 2'h0;
	localparam logic [5:0] SAP_RST_WIDTH = 6'h10;
	localparam logic [6:0] SAP_RST_RATIO = 7'h40;
	localparam logic [4:0] SAP_RST_RX_THR = 5'h08;
	localparam logic [3:0] SAP_RST_TX_THR = 4'h8;
	localparam logic [4:0] SAP_RX_THR_MAX = 5'h10;

	typedef enum logic [1:0] {SAP_DIR_OFF, SAP_DIR_RX, SAP_DIR_TX, SAP_DIR_BOTH} sap_dir_type;
	typedef enum logic [1:0] {SAP_FMT_I2S, SAP_FMT_LEFT, SAP_FMT_RIGHT} sap_fmt_type;

	function automatic logic sap_width_ok(input logic [5:0] w, input logic enh);
		sap_width_ok = (w == 6'h08) || (w == 6'h10) || (w == 6'h12) || (w == 6'h14) ||
			(w == 6'h16) || (w == 6'h18) || (enh && (w == 6'h20));
	endfunction : sap_width_ok

	function automatic logic sap_ratio_ok(input logic [6:0] r);
		sap_ratio_ok = (r == 7'h10) || (r == 7'h20) || (r == 7'h30) || (r == 7'h40);
	endfunction : sap_ratio_ok

	function automatic logic [31:0] sap_swap(input logic [31:0] d, input logic en);
		sap_swap = en ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
	endfunction : sap_swap

endpackage : sap_pkg

/* File: rtl/sap_port.sv */
// Summary of operation
// - basic 8-bit: rx flag at 4/8/12
// - basic 16-bit: rx flag at 2/4/6
// - basic wider samples: rx flag at 1/2/3
// - enhanced: tx flag at level <= 0..15
// - enhanced: rx flag at level >= 1..16
// - per-channel byte reversal on fifo access
// - four directions; channel 1 never both
// - formats I2S, left and right justified
// - widths 8..24, enhanced adds 32
// - bit clock 16, 32, 48, 64 Fs
// - one master ratio for both channels
// - mode 0 drives clocks, 1 accepts
// - basic 8-bit: tx flag at 12/8/4
module sap_port
	import sap_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// interrupt
	output logic irq,
	// bit clock pins, per channel
	input wire logic [1:0] bit_clock_in,
	output logic [1:0] bit_clock_out,
	output logic [1:0] bit_clock_oe,
	// word select clock pins, per channel
	input wire logic [1:0] word_select_clock_in,
	output logic [1:0] word_select_clock_out,
	output logic [1:0] word_select_clock_oe,
	// serial data pins, per channel
	input wire logic [1:0] serial_data_in,
	output logic [1:0] serial_data_out
);

	localparam int unsigned NST = SAP_CHANNELS * SAP_ST_PER_CH;

	logic rst_sync1_b;
	logic rst_int_b;
	logic [1:0] bclk_s1, bclk_s2, ws_s1, ws_s2, din_s1, din_s2;
	logic enhanced_sound_port;
	logic [13:0] master_clock_ratio;
	logic [NST-1:0] status, mask, events;
	logic [31:0] ch_rd [SAP_CHANNELS];

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync1_b <= 1'b0;
			rst_int_b <= 1'b0;
		end else begin
			rst_sync1_b <= 1'b1;
			rst_int_b <= rst_sync1_b;
		end
	end

	// pin synchronisers
	always_ff @(posedge clock or negedge rst_int_b) begin
		if (!rst_int_b) begin
			bclk_s1 <= 2'h0;
			bclk_s2 <= 2'h0;
			ws_s1 <= 2'h0;
			ws_s2 <= 2'h0;
			din_s1 <= 2'h0;
			din_s2 <= 2'h0;
		end else begin
			bclk_s1 <= bit_clock_in;
			bclk_s2 <= bclk_s1;
			ws_s1 <= word_select_clock_in;
			ws_s2 <= ws_s1;
			din_s1 <= serial_data_in;
			din_s2 <= din_s1;
		end
	end

	// global control and the shared master clock ratio
	always_ff @(posedge clock or negedge rst_int_b) begin
		if (!rst_int_b) begin
			enhanced_sound_port <= SAP_RST_ENHANCED;
			master_clock_ratio <= SAP_RST_MCLK;
			mask <= '0;
		end else if (wr) begin
			if (addr == SAP_OFF_CONTROL) begin
				enhanced_sound_port <= wdata[0];
			end else if (addr == SAP_OFF_MCLK) begin
				if (wdata[13:0] >= SAP_MCLK_MIN && wdata[13:0] <= SAP_MCLK_MAX &&
						wdata[31:14] == 18'h0_0000) begin
					master_clock_ratio <= wdata[13:0];
				end
			end else if (addr == SAP_OFF_MASK) begin
				mask <= wdata[NST-1:0];
			end
		end
	end

	// sticky status, write one to clear, a new event wins over the clear
	always_ff @(posedge clock or negedge rst_int_b) begin
		if (!rst_int_b) begin
			status <= '0;
		end else if (wr && addr == SAP_OFF_STATUS) begin
			status <= (status & ~wdata[NST-1:0]) | events;
		end else begin
			status <= status | events;
		end
	end

	assign irq = |(status & mask);

	always_ff @(posedge clock or negedge rst_int_b) begin
		if (!rst_int_b) begin
			rdata <= 32'h0000_0000;
		end else begin
			rdata <= 32'h0000_0000;
			if (rd) begin
				if (addr == SAP_OFF_CONTROL) begin
					rdata <= {31'h0000_0000, enhanced_sound_port};
				end else if (addr == SAP_OFF_MCLK) begin
					rdata <= {18'h0_0000, master_clock_ratio};
				end else if (addr == SAP_OFF_STATUS) begin
					rdata <= {{(32 - NST){1'b0}}, status};
				end else if (addr == SAP_OFF_MASK) begin
					rdata <= {{(32 - NST){1'b0}}, mask};
				end else if ((addr & SAP_CH_MASK) == SAP_CH_BASE) begin
					rdata <= ch_rd[0];
				end else if ((addr & SAP_CH_MASK) == 8'(SAP_CH_BASE + SAP_CH_STRIDE)) begin
					rdata <= ch_rd[1];
				end
			end
		end
	end

	for (genvar i = 0; i < SAP_CHANNELS; i++) begin : g_ch
		logic hit;
		logic [7:0] loc;
		logic [1:0] channel_direction_select;
		logic [1:0] frame_format_select;
		logic clock_direction_select;
		logic fifo_byte_reverse;
		logic [5:0] sample_width_select;
		logic [6:0] bit_clock_ratio;
		logic [4:0] rx_full_threshold;
		logic [3:0] tx_empty_threshold;
		logic active, tx_on, rx_on;
		logic [31:0] tx_mem [SAP_FIFO_DEPTH];
		logic [31:0] rx_mem [SAP_FIFO_DEPTH];
		logic [SAP_PTR_W-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
		logic [SAP_LVL_W-1:0] tx_cnt, rx_cnt, unit, tx_lim, rx_lim;
		logic [1:0] code;
		logic tx_empty_flag, rx_full_flag;
		logic tx_push, tx_pop, rx_push, rx_pop, under, over;
		logic [14:0] acc, next_sum;
		logic bclk_q, ws_q, lvl, lvl_d, fall, rise, ws_last, new_word, started;
		logic [5:0] slot, bitcnt, next_bitcnt, off, k_out, k_in, idx;
		logic [31:0] tx_word, word_now, rx_acc;
		logic dout;

		assign hit = (addr & SAP_CH_MASK) == 8'(SAP_CH_BASE + i * SAP_CH_STRIDE);
		assign loc = addr & ~SAP_CH_MASK;

		always_ff @(posedge clock or negedge rst_int_b) begin
			if (!rst_int_b) begin
				channel_direction_select <= (i == 0) ? SAP_RST_DIR_CH0 : SAP_RST_DIR_CH1;
				frame_format_select <= SAP_FMT_I2S;
				clock_direction_select <= 1'b0;
				fifo_byte_reverse <= 1'b0;
				sample_width_select <= SAP_RST_WIDTH;
				bit_clock_ratio <= SAP_RST_RATIO;
				rx_full_threshold <= SAP_RST_RX_THR;
				tx_empty_threshold <= SAP_RST_TX_THR;
			end else if (wr && hit && loc == SAP_CH_CONFIG) begin
				if (!(i == 1 && wdata[SAP_CFG_DIR_LSB +: 2] == SAP_DIR_BOTH)) begin
					channel_direction_select <= wdata[SAP_CFG_DIR_LSB +: 2];
				end
				if (wdata[SAP_CFG_FMT_LSB +: 2] != 2'h3) begin
					frame_format_select <= wdata[SAP_CFG_FMT_LSB +: 2];
				end
				clock_direction_select <= wdata[SAP_CFG_SLAVE_BIT];
				fifo_byte_reverse <= wdata[SAP_CFG_SWAP_BIT];
				if (sap_width_ok(wdata[SAP_CFG_WIDTH_LSB +: 6], enhanced_sound_port)) begin
					sample_width_select <= wdata[SAP_CFG_WIDTH_LSB +: 6];
				end
				if (sap_ratio_ok(wdata[SAP_CFG_RATIO_LSB +: 7])) begin
					bit_clock_ratio <= wdata[SAP_CFG_RATIO_LSB +: 7];
				end
			end else if (wr && hit && loc == SAP_CH_THRESH) begin
				if (wdata[SAP_THR_RX_LSB +: 5] != 5'h00 &&
						wdata[SAP_THR_RX_LSB +: 5] <= SAP_RX_THR_MAX) begin
					rx_full_threshold <= wdata[SAP_THR_RX_LSB +: 5];
				end
				tx_empty_threshold <= wdata[SAP_THR_TX_LSB +: 4];
			end
		end

		assign active = channel_direction_select != SAP_DIR_OFF;
		assign tx_on = channel_direction_select[1];
		assign rx_on = channel_direction_select[0];

		// basic variant: threshold code picks a multiple of a width dependent unit
		always_comb begin
			code = (tx_empty_threshold[1:0] == 2'h3) ? 2'h2 : tx_empty_threshold[1:0];
			if (sample_width_select == 6'h08) begin
				unit = 5'h04;
			end else if (sample_width_select == 6'h10) begin
				unit = 5'h02;
			end else begin
				unit = 5'h01;
			end
			if (enhanced_sound_port) begin
				tx_lim = {1'b0, tx_empty_threshold};
				rx_lim = rx_full_threshold;
			end else begin
				tx_lim = 5'((3 - code) * unit);
				rx_lim = 5'((rx_full_threshold[1:0] == 2'h3 ? 2'h3 : rx_full_threshold[1:0] + 2'h1) * unit);
			end
		end

		assign tx_empty_flag = tx_cnt <= tx_lim;
		assign rx_full_flag = rx_cnt >= rx_lim;

		assign tx_push = wr && hit && loc == SAP_CH_TXDATA && tx_cnt != 5'(SAP_FIFO_DEPTH);
		assign tx_pop = fall && new_word && tx_on && tx_cnt != 5'h00;
		assign under = fall && new_word && tx_on && tx_cnt == 5'h00;
		assign rx_push = fall && new_word && rx_on && started && rx_cnt != 5'(SAP_FIFO_DEPTH);
		assign over = fall && new_word && rx_on && started && rx_cnt == 5'(SAP_FIFO_DEPTH);
		assign rx_pop = rd && hit && loc == SAP_CH_RXDATA && rx_cnt != 5'h00;

		always_ff @(posedge clock) begin
			if (tx_push) begin
				tx_mem[tx_wp] <= sap_swap(wdata, fifo_byte_reverse);
			end
			if (rx_push) begin
				rx_mem[rx_wp] <= rx_acc;
			end
		end

		always_ff @(posedge clock or negedge rst_int_b) begin
			if (!rst_int_b) begin
				tx_wp <= '0;
				tx_rp <= '0;
				tx_cnt <= '0;
				rx_wp <= '0;
				rx_rp <= '0;
				rx_cnt <= '0;
			end else begin
				tx_wp <= tx_wp + SAP_PTR_W'(tx_push);
				tx_rp <= tx_rp + SAP_PTR_W'(tx_pop);
				tx_cnt <= tx_cnt + SAP_LVL_W'(tx_push) - SAP_LVL_W'(tx_pop);
				rx_wp <= rx_wp + SAP_PTR_W'(rx_push);
				rx_rp <= rx_rp + SAP_PTR_W'(rx_pop);
				rx_cnt <= rx_cnt + SAP_LVL_W'(rx_push) - SAP_LVL_W'(rx_pop);
			end
		end

		// master bit clock: fractional divide of the shared master clock ratio
		assign next_sum = acc + {7'h00, bit_clock_ratio, 1'b0};
		always_ff @(posedge clock or negedge rst_int_b) begin
			if (!rst_int_b) begin
				acc <= '0;
				bclk_q <= 1'b0;
			end else if (!active || clock_direction_select) begin
				acc <= '0;
				bclk_q <= 1'b0;
			end else if (next_sum >= {1'b0, master_clock_ratio}) begin
				acc <= next_sum - {1'b0, master_clock_ratio};
				bclk_q <= ~bclk_q;
			end else begin
				acc <= next_sum;
			end
		end

		// slave mode takes both clocks from the converter
		assign lvl = clock_direction_select ? bclk_s2[i] : bclk_q;
		assign fall = lvl_d && !lvl;
		assign rise = !lvl_d && lvl;
		assign slot = {1'b0, bit_clock_ratio[6:2]} << 1;
		assign new_word = clock_direction_select ? (ws_s2[i] != ws_last) : (bitcnt == slot - 6'h01);
		assign next_bitcnt = new_word ? 6'h00 : bitcnt + 6'h01;

		always_comb begin
			if (frame_format_select == SAP_FMT_I2S) begin
				off = 6'h01;
			end else if (frame_format_select == SAP_FMT_LEFT) begin
				off = 6'h00;
			end else begin
				off = (slot > sample_width_select) ? slot - sample_width_select : 6'h00;
			end
		end

		assign word_now = !new_word ? tx_word :
			(tx_cnt != 5'h00 ? tx_mem[tx_rp] : 32'h0000_0000);
		assign k_out = next_bitcnt - off;
		assign k_in = bitcnt - off;
		assign idx = sample_width_select - 6'h01 - k_out;

		always_ff @(posedge clock or negedge rst_int_b) begin
			if (!rst_int_b) begin
				lvl_d <= 1'b0;
				ws_last <= 1'b0;
				ws_q <= 1'b0;
				bitcnt <= '0;
				started <= 1'b0;
				tx_word <= 32'h0000_0000;
				rx_acc <= 32'h0000_0000;
				dout <= 1'b0;
			end else if (!active) begin
				lvl_d <= 1'b0;
				ws_q <= 1'b0;
				bitcnt <= '0;
				started <= 1'b0;
				dout <= 1'b0;
			end else begin
				lvl_d <= lvl;
				if (fall) begin
					ws_last <= ws_s2[i];
					bitcnt <= next_bitcnt;
					if (new_word) begin
						ws_q <= ~ws_q;
						started <= 1'b1;
						tx_word <= word_now;
						rx_acc <= 32'h0000_0000;
					end
					if (tx_on && next_bitcnt >= off && k_out < sample_width_select) begin
						dout <= word_now[idx[4:0]];
					end else begin
						dout <= 1'b0;
					end
				end else if (rise && rx_on && bitcnt >= off && k_in < sample_width_select) begin
					rx_acc <= {rx_acc[30:0], din_s2[i]};
				end
			end
		end

		assign bit_clock_out[i] = bclk_q;
		assign bit_clock_oe[i] = active && !clock_direction_select;
		assign word_select_clock_out[i] = ws_q ^ (frame_format_select != SAP_FMT_I2S);
		assign word_select_clock_oe[i] = active && !clock_direction_select;
		assign serial_data_out[i] = dout;

		assign events[i * SAP_ST_PER_CH + SAP_ST_TXE] = tx_empty_flag && tx_on;
		assign events[i * SAP_ST_PER_CH + SAP_ST_RXF] = rx_full_flag && rx_on;
		assign events[i * SAP_ST_PER_CH + SAP_ST_UNDER] = under;
		assign events[i * SAP_ST_PER_CH + SAP_ST_OVER] = over;

		always_comb begin
			ch_rd[i] = 32'h0000_0000;
			if (loc == SAP_CH_CONFIG) begin
				ch_rd[i] = {9'h000, bit_clock_ratio, 2'h0, sample_width_select, 2'h0,
					fifo_byte_reverse, clock_direction_select, frame_format_select,
					channel_direction_select};
			end else if (loc == SAP_CH_THRESH) begin
				ch_rd[i] = {20'h0_0000, tx_empty_threshold, 3'h0, rx_full_threshold};
			end else if (loc == SAP_CH_RXDATA) begin
				if (rx_cnt != 5'h00) begin
					ch_rd[i] = sap_swap(rx_mem[rx_rp], fifo_byte_reverse);
				end
			end else if (loc == SAP_CH_LEVEL) begin
				ch_rd[i] = {14'h0000, rx_full_flag, tx_empty_flag, 3'h0, rx_cnt, 3'h0, tx_cnt};
			end
		end
	end

endmodule : sap_port

/* File: bench/sap_port_asserts.sv */
module sap_port_asserts
	import sap_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic irq,
	// link pins
	input wire logic [1:0] bit_clock_in,
	input wire logic [1:0] bit_clock_out,
	input wire logic [1:0] bit_clock_oe,
	input wire logic [1:0] word_select_clock_in,
	input wire logic [1:0] word_select_clock_out,
	input wire logic [1:0] word_select_clock_oe,
	input wire logic [1:0] serial_data_in,
	input wire logic [1:0] serial_data_out
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	a_ctrl_readback: assert property (
		(wr && addr == SAP_OFF_CONTROL) ##2 (rd && addr == SAP_OFF_CONTROL)
		|=> rdata[0] == $past(wdata[0], 3)) else $error("variant bit readback wrong");
	a_mclk_shared: assert property (
		(wr && addr == SAP_OFF_MCLK && wdata[13:0] inside {[SAP_MCLK_MIN:SAP_MCLK_MAX]})
		##2 (rd && addr == SAP_OFF_MCLK)
		|=> rdata[13:0] == $past(wdata[13:0], 3)) else $error("master ratio readback wrong");
	a_ch1_no_both: assert property (
		(wr && addr == 8'h40 && wdata[1:0] == 2'h3) ##2 (rd && addr == 8'h40)
		|=> rdata[1:0] != 2'h3) else $error("channel 1 took both directions");
	a_irq_masked: assert property (
		wr && addr == SAP_OFF_MASK && wdata == 32'h0000_0000 |=> !irq)
		else $error("irq high with mask clear");
	a_oe_pair: assert property (
		bit_clock_oe == word_select_clock_oe) else $error("clock enables differ");
	a_slave_release: assert property (
		wr && addr == 8'h40 && wdata[4] |-> ##2 !bit_clock_oe[1] && !word_select_clock_oe[1])
		else $error("slave channel drives clocks");
	a_bclk_hold: assert property (
		($rose(bit_clock_out[0]) && bit_clock_oe[0] ##1 bit_clock_oe[0]) |-> bit_clock_out[0])
		else $error("bit clock high too short");
	a_sdo_quiet: assert property (
		!bit_clock_oe[0] && !$past(bit_clock_oe[0], 2) |-> serial_data_out[0] == 1'b0)
		else $error("data out while channel off");
endmodule : sap_port_asserts

bind sap_port sap_port_asserts i_asserts (.clock, .rst_b, .addr, .wdata, .wr, .rd, .rdata,
	.irq, .bit_clock_in, .bit_clock_out, .bit_clock_oe, .word_select_clock_in,
	.word_select_clock_out, .word_select_clock_oe, .serial_data_in, .serial_data_out);

/* File: bench/sap_codec_model.sv */
// left-justified 32-bit converter that supplies both clocks
module sap_codec_model (
	// control
	input wire logic run,
	// link
	output logic bclk,
	output logic ws,
	output logic sd
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] SAMPLE = 32'h1234_5678;
	int bit_idx;

	initial begin
		bclk = 1'b1;
		ws = 1'b0;
		sd = 1'b0;
		bit_idx = 0;
		forever begin
			if (run) begin
				#100 bclk = 1'b0;
				if (bit_idx == 0) ws = ~ws;
				sd = SAMPLE[31 - bit_idx];
				bit_idx = (bit_idx + 1) % 32;
				#100 bclk = 1'b1;
			end else begin
				// idle data line never holds a stale bit
				#25 sd = ~sd;
			end
		end
	end
endmodule : sap_codec_model

/* File: bench/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import sap_pkg::*;
	localparam logic [7:0] CH0 = 8'h20;
	localparam logic [7:0] CH1 = 8'h40;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic run = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata;
	logic [31:0] got;
	logic irq;
	logic [1:0] bco, bcoe, wso, wsoe, sdo;
	logic m_bclk, m_ws, m_sd;
	int err_total = 0;
	int cmp_count = 0;
	int cycles = 0;
	int t;
	logic [31:0] cfgs[14] = '{32'h0040_1001, 32'h0040_1002, 32'h0040_1004, 32'h0040_1008,
		32'h0040_0800, 32'h0040_1200, 32'h0040_1400, 32'h0040_1600, 32'h0040_1800,
		32'h0040_2000, 32'h0010_1000, 32'h0020_1000, 32'h0030_1000, 32'h0040_1000};
	wire logic [1:0] bc_pin = {bcoe[1] ? bco[1] : m_bclk, bcoe[0] & bco[0]};
	wire logic [1:0] ws_pin = {wsoe[1] ? wso[1] : m_ws, wsoe[0] & wso[0]};

	sap_port i_dut (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .irq(irq), .bit_clock_in(bc_pin), .bit_clock_out(bco),
		.bit_clock_oe(bcoe), .word_select_clock_in(ws_pin), .word_select_clock_out(wso),
		.word_select_clock_oe(wsoe), .serial_data_in({m_sd, sdo[0]}),
		.serial_data_out(sdo));
	sap_codec_model i_codec (.run(run), .bclk(m_bclk), .ws(m_ws), .sd(m_sd));

	always #12.5 clock = ~clock;

	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			err_total++;
			summarize();
		end
	end

	task automatic summarize;
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : summarize

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		// one idle edge so a following write never re-raises wr in this step
		@(posedge clock);
	endtask : wreg

	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 d = rdata;
		@(posedge clock);
	endtask : rreg

	task automatic flag(input int b, input int e);
		rreg(CH1 + SAP_CH_LEVEL, got);
		chk("flag", 32'(got[b]), 32'(e));
	endtask : flag

	// basic variant: threshold code scaled by sample width
	task automatic basic(input int n, input int b, input int sw);
		int wd[3] = '{8, 16, 24};
		int un[3] = '{4, 2, 1};
		wreg(SAP_OFF_CONTROL, 32'h0);
		for (int i = 0; i < 3; i++) begin
			for (int c = 0; c < 3; c++) begin
				wreg(CH1 + SAP_CH_CONFIG, 32'h0040_0000 | 32'((wd[i] << 8) | (sw << 5)));
				wreg(CH1 + SAP_CH_THRESH, 32'((c << 8) | c | 4));
				flag(b, b == 16 ? n <= (3 - c) * un[i] : n >= (c + 1) * un[i]);
			end
		end
		wreg(SAP_OFF_CONTROL, 32'h1);
	endtask : basic

	initial begin
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		repeat (3) @(posedge clock);
		chk("oe", {30'h0, bcoe}, 32'h1);
		rreg(SAP_OFF_MCLK, got);
		chk("mclk", got, 32'h0000_0100);
		rreg(CH0 + SAP_CH_CONFIG, got);
		chk("cfg0", got, 32'h0040_1002);
		rreg(CH0 + SAP_CH_THRESH, got);
		chk("thr0", got, 32'h0000_0808);
		repeat (20) @(posedge clock);
		wreg(SAP_OFF_MASK, 32'h1);
		rreg(SAP_OFF_STATUS, got);
		chk("txe status", 32'(got[0]), 32'h1);
		chk("irq on", 32'(irq), 32'h1);
		wreg(SAP_OFF_MASK, 32'h0);
		wreg(SAP_OFF_MASK, 32'h1);
		wreg(CH0 + SAP_CH_CONFIG, 32'h0040_1000);
		repeat (4) @(posedge clock);
		wreg(SAP_OFF_STATUS, 32'h0000_00FF);
		rreg(SAP_OFF_STATUS, got);
		chk("status", got, 32'h0);
		chk("irq off", 32'(irq), 32'h0);
		wreg(SAP_OFF_MASK, 32'h0);
		$display("done irq");
		wreg(SAP_OFF_CONTROL, 32'h0);
		rreg(SAP_OFF_CONTROL, got);
		chk("variant", got, 32'h0);
		wreg(SAP_OFF_CONTROL, 32'h1);
		wreg(SAP_OFF_MCLK, 32'h0000_2000);
		rreg(SAP_OFF_MCLK, got);
		wreg(SAP_OFF_MCLK, 32'h0000_2001);
		wreg(SAP_OFF_MCLK, 32'h0000_000F);
		rreg(SAP_OFF_MCLK, got);
		chk("mclk max", got, 32'h0000_2000);
		wreg(SAP_OFF_MCLK, 32'h0000_0100);
		wreg(CH0 + SAP_CH_CONFIG, 32'h0040_1003);
		rreg(CH0 + SAP_CH_CONFIG, got);
		chk("ch0 both", got, 32'h0040_1003);
		wreg(CH0 + SAP_CH_CONFIG, 32'h0040_1000);
		wreg(CH1 + SAP_CH_CONFIG, 32'h0040_100F);
		rreg(CH1 + SAP_CH_CONFIG, got);
		chk("ch1 both", got, 32'h0040_1000);
		wreg(CH1 + SAP_CH_CONFIG, 32'h0028_1000);
		rreg(CH1 + SAP_CH_CONFIG, got);
		chk("bad ratio", got, 32'h0040_1000);
		foreach (cfgs[i]) begin
			wreg(CH1 + SAP_CH_CONFIG, cfgs[i]);
			rreg(CH1 + SAP_CH_CONFIG, got);
			chk("cfg1", got, cfgs[i]);
		end
		rreg(8'h80, got);
		chk("unmapped", got, 32'h0);
		$display("done registers");
		for (int n = 1; n <= 16; n++) begin
			wreg(CH1 + SAP_CH_TXDATA, 32'(n));
			for (int k = 0; k < 4; k++) begin
				t = k == 0 ? 0 : k == 3 ? 15 : n + k - 2;
				if (t <= 15) begin
					wreg(CH1 + SAP_CH_THRESH, 32'((t << 8) | 8));
					flag(16, n <= t);
				end
			end
			basic(n, 16, 0);
		end
		wreg(CH1 + SAP_CH_TXDATA, 32'h11);
		rreg(CH1 + SAP_CH_LEVEL, got);
		chk("tx count", 32'(got[4:0]), 32'h10);
		$display("done transmit flags");
		wreg(CH1 + SAP_CH_CONFIG, 32'h0040_2015);
		run <= 1'b1;
		repeat (6000) @(posedge clock);
		chk("slave oe", {30'h0, bcoe | wsoe}, 32'h0);
		run <= 1'b0;
		repeat (600) @(posedge clock);
		wreg(CH1 + SAP_CH_CONFIG, 32'h0040_2014);
		rreg(CH1 + SAP_CH_LEVEL, got);
		chk("rx count", 32'(got[12:8]), 32'h10);
		for (int n = 16; n >= 1; n--) begin
			for (int k = 0; k < 3; k++) begin
				t = k == 0 ? 1 : n + k - 1;
				if (t <= 16) begin
					wreg(CH1 + SAP_CH_THRESH, 32'h0000_0800 | 32'(t));
					flag(17, n >= t);
				end
			end
			basic(n, 17, n % 2);
			wreg(CH1 + SAP_CH_CONFIG, 32'h0040_2014 | 32'((n % 2) << 5));
			rreg(CH1 + SAP_CH_RXDATA, got);
			chk("rx word", got, n % 2 ? 32'h7856_3412 : 32'h1234_5678);
		end
		$display("done receive flags");
		summarize();
	end
endmodule : testbench
